// ==== rtl/adc_fmt_params.svh ====
`ifndef ADC_FMT_PARAMS_SVH
`define ADC_FMT_PARAMS_SVH

// ==================== register offsets ====================
`define OFS_SELECT 8'h00
`define OFS_RESULT_LO 8'h04
`define OFS_RESULT_HI 8'h08
`define OFS_CONTROL 8'h0C
`define OFS_IRQ_STATUS 8'h10
`define OFS_IRQ_MASK 8'h14
`define OFS_APPLIED 8'h18

// ==================== field positions ====================
`define SEL_REF_MSB 7
`define SEL_REF_LSB 6
`define SEL_LEFT_BIT 5
`define SEL_CHAN_MSB 4
`define SEL_CHAN_LSB 0
`define CTRL_START_BIT 0
`define CTRL_BUSY_BIT 1
`define IRQ_DONE_BIT 0

// ==================== reset values and codes ====================
`define SELECT_RESET 8'h00
`define REF_EXTERNAL 2'h0
`define REF_SUPPLY 2'h1
`define REF_RESERVED 2'h2
`define REF_INTERNAL 2'h3
`define SE_MAX_CODE 10'h3FF
`define DIFF_MAX_CODE 10'h1FF
`define DIFF_MIN_CODE 10'h200
`define DIFF_CHAN_BIT 4
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

// ==== rtl/adc_fmt_pkg.sv ====
package adc_fmt_pkg;
	// ==================== selection fields ====================
	typedef struct packed {
		logic [1:0] reference_select;
		logic left_adjust_result;
		logic [4:0] channel_select;
	} select_t;

	// ==================== applied routing to the analog core ====================
	typedef struct packed {
		logic ref_external;
		logic ref_supply;
		logic ref_internal;
		logic differential;
		logic [4:0] channel;
	} route_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONVERT = 3'b010,
		ST_FINISH = 3'b100
	} conv_state_t;
endpackage : adc_fmt_pkg

// ==== rtl/result_code_shaper.sv ====
`timescale 1ns/1ps
`include "adc_fmt_params.svh"
module result_code_shaper (
	input wire logic signed [11:0] i_raw, // core estimate, wider than result
	input wire logic i_differential, // differential routing active
	output logic [9:0] o_code // shaped 10-bit code
);
	// ==================== saturation ====================
	// clamping here lets the core overshoot without wrapping into the wrong sign
	always_comb begin
		if (i_differential) begin
			if (i_raw > $signed(12'sh1FF))
				o_code = `DIFF_MAX_CODE;
			else if (i_raw < $signed(-12'sh200))
				o_code = `DIFF_MIN_CODE;
			else
				o_code = i_raw[9:0];
		end else begin
			if (i_raw < $signed(12'sh000))
				o_code = 10'h000;
			else if (i_raw > $signed(12'sh3FF))
				o_code = `SE_MAX_CODE;
			else
				o_code = i_raw[9:0];
		end
	end
endmodule : result_code_shaper

// ==== rtl/result_aligner.sv ====
`timescale 1ns/1ps
module result_aligner (
	input wire logic [9:0] i_code, // stored result
	input wire logic i_left, // live left adjust setting
	output logic [7:0] o_low, // low result byte
	output logic [7:0] o_high // high result byte
);
	// ==================== byte layout ====================
	// purely combinational so a setting change shows on the next read
	always_comb begin
		if (i_left) begin
			o_high = i_code[9:2];
			o_low = {i_code[1:0], 6'h00};
		end else begin
			o_high = {6'h00, i_code[9:8]};
			o_low = i_code[7:0];
		end
	end
endmodule : result_aligner

// ==== rtl/adc_result_format_ref_select.sv ====
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "adc_fmt_params.svh"
module adc_result_format_ref_select (
	input wire logic i_clock, // 40 MHz system clock
	input wire logic i_arst_n, // async reset, active low
	input wire logic [7:0] i_awaddr, // write address
	input wire logic [2:0] i_awprot, // write protection, unused
	input wire logic i_awvalid, // write address valid
	output logic o_awready, // write address ready
	input wire logic [31:0] i_wdata, // write data
	input wire logic [3:0] i_wstrb, // write byte strobes
	input wire logic i_wvalid, // write data valid
	output logic o_wready, // write data ready
	output logic [1:0] o_bresp, // write response
	output logic o_bvalid, // write response valid
	input wire logic i_bready, // write response ready
	input wire logic [7:0] i_araddr, // read address
	input wire logic [2:0] i_arprot, // read protection, unused
	input wire logic i_arvalid, // read address valid
	output logic o_arready, // read address ready
	output logic [31:0] o_rdata, // read data
	output logic [1:0] o_rresp, // read response
	output logic o_rvalid, // read valid
	input wire logic i_rready, // read ready
	output logic o_conv_start, // one-cycle start pulse to core
	input wire logic i_conv_done, // core finished, one-cycle pulse
	input wire logic signed [11:0] i_conv_raw, // core estimate with done
	output adc_fmt_pkg::route_t o_route, // applied reference and channel
	output logic o_irq // level interrupt
);
	// ==================== register state ====================
	adc_fmt_pkg::select_t select_ff; // software-visible selection
	adc_fmt_pkg::route_t route_ff; // what the core is really using
	adc_fmt_pkg::conv_state_t state_ff;
	logic [9:0] result_ff;
	logic done_flag_ff; // conversion_done_flag
	logic irq_mask_ff;
	logic start_ff;
	logic irq_ff;
	logic aw_held_ff;
	logic w_held_ff;
	logic awready_ff; // registered copy of the free address slot
	logic wready_ff; // registered copy of the free data slot
	logic arready_ff; // registered copy of the free read slot
	logic [7:0] awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic bvalid_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [9:0] shaped_code;
	logic [7:0] low_byte;
	logic [7:0] high_byte;
	logic wr_fire;
	logic start_req;
	logic clear_done;
	adc_fmt_pkg::route_t nxt_route;
	logic [31:0] nxt_rdata;
	logic [1:0] nxt_rresp;
	logic [1:0] nxt_bresp;
	logic chan_is_diff;

	// ==================== write channel ====================
	// address and data accepted independently, response after both
	assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
	// address is parked until the data word has arrived as well
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= 8'h00;
		end else if (i_awvalid && !aw_held_ff) begin
			aw_held_ff <= 1'b1;
			awaddr_ff <= i_awaddr;
		end else if (wr_fire) begin
			aw_held_ff <= 1'b0;
		end
	end

	// data word is parked until the address has arrived as well
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			w_held_ff <= 1'b0;
			wdata_ff <= 32'h00000000;
			wstrb_ff <= 4'h0;
		end else if (i_wvalid && !w_held_ff) begin
			w_held_ff <= 1'b1;
			wdata_ff <= i_wdata;
			wstrb_ff <= i_wstrb;
		end else if (wr_fire) begin
			w_held_ff <= 1'b0;
		end
	end

	// ready kept in its own flop so the port carries no gate after the register
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			awready_ff <= 1'b1;
		end else if (i_awvalid && awready_ff) begin
			awready_ff <= 1'b0;
		end else if (wr_fire) begin
			awready_ff <= 1'b1;
		end
	end

	// same for the data channel; it always equals the inverse of the holding flag
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wready_ff <= 1'b1;
		end else if (i_wvalid && wready_ff) begin
			wready_ff <= 1'b0;
		end else if (wr_fire) begin
			wready_ff <= 1'b1;
		end
	end

	assign o_awready = awready_ff;
	assign o_wready = wready_ff;

	// unmapped or read-only targets answer SLVERR and change nothing
	always_comb begin
		case (awaddr_ff)
			`OFS_SELECT, `OFS_CONTROL, `OFS_IRQ_STATUS, `OFS_IRQ_MASK: nxt_bresp = `AXI_OKAY;
			default: nxt_bresp = `AXI_SLVERR;
		endcase
	end

	// response stands until the master takes it
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bvalid_ff <= 1'b0;
			o_bresp <= `AXI_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			o_bresp <= nxt_bresp;
		end else if (i_bready) begin
			bvalid_ff <= 1'b0;
		end
	end
	assign o_bvalid = bvalid_ff;

	// ==================== selection register ====================
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			select_ff <= adc_fmt_pkg::select_t'(`SELECT_RESET);
		end else if (wr_fire && awaddr_ff == `OFS_SELECT && wstrb_ff[0]) begin
			select_ff <= adc_fmt_pkg::select_t'(wdata_ff[7:0]);
		end
	end

	// ==================== control decode ====================
	// start and clear act only on a committed write with the low byte enabled
	assign start_req = wr_fire && awaddr_ff == `OFS_CONTROL && wstrb_ff[0] && wdata_ff[`CTRL_START_BIT];
	assign clear_done = wr_fire && awaddr_ff == `OFS_IRQ_STATUS && wstrb_ff[0] && wdata_ff[`IRQ_DONE_BIT];

	// mask gates the level output only; the flag itself stays sticky
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			irq_mask_ff <= 1'b0;
		end else if (wr_fire && awaddr_ff == `OFS_IRQ_MASK && wstrb_ff[0]) begin
			irq_mask_ff <= wdata_ff[`IRQ_DONE_BIT];
		end
	end

	// ==================== routing decode ====================
	// codes 11110 and 11111 pick fixed single-ended sources although the top bit is set
	assign chan_is_diff = select_ff.channel_select[`DIFF_CHAN_BIT] && select_ff.channel_select[3:1] != 3'h7;

	// reserved reference code selects nothing rather than guessing a source
	always_comb begin
		nxt_route.ref_external = select_ff.reference_select == `REF_EXTERNAL;
		nxt_route.ref_supply = select_ff.reference_select == `REF_SUPPLY;
		nxt_route.ref_internal = select_ff.reference_select == `REF_INTERNAL;
		nxt_route.differential = chan_is_diff;
		nxt_route.channel = select_ff.channel_select;
	end

	// ==================== conversion sequencer ====================
	// idle tracks the selection every cycle, so a start always uses the latest write
	// convert freezes routing; a selection write then lands in select_ff only
	// finish copies the pending selection once the result has been stored
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_ff <= adc_fmt_pkg::ST_IDLE;
			start_ff <= 1'b0;
			route_ff <= '0;
		end else begin
			start_ff <= 1'b0;
			case (state_ff)
				adc_fmt_pkg::ST_IDLE: begin
					route_ff <= nxt_route;
					if (start_req) begin
						start_ff <= 1'b1;
						state_ff <= adc_fmt_pkg::ST_CONVERT;
					end
				end
				adc_fmt_pkg::ST_CONVERT: begin
					if (i_conv_done)
						state_ff <= adc_fmt_pkg::ST_FINISH;
				end
				adc_fmt_pkg::ST_FINISH: begin
					route_ff <= nxt_route;
					state_ff <= adc_fmt_pkg::ST_IDLE;
				end
				default: state_ff <= adc_fmt_pkg::ST_IDLE;
			endcase
		end
	end
	assign o_conv_start = start_ff;
	assign o_route = route_ff;

	// ==================== result capture ====================
	// shaping follows the applied routing, not the live selection
	result_code_shaper i_result_code_shaper (
		.i_raw(i_conv_raw),
		.i_differential(route_ff.differential),
		.o_code(shaped_code)
	);

	// result and flag move in the same edge, so a read never sees a stale pair
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			result_ff <= 10'h000;
		end else if (state_ff == adc_fmt_pkg::ST_CONVERT && i_conv_done) begin
			result_ff <= shaped_code;
		end
	end

	// set wins over a simultaneous clear
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			done_flag_ff <= 1'b0;
		end else if (state_ff == adc_fmt_pkg::ST_CONVERT && i_conv_done) begin
			done_flag_ff <= 1'b1;
		end else if (clear_done) begin
			done_flag_ff <= 1'b0;
		end
	end

	// level output trails the flag by one cycle so it comes straight from a flop
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n)
			irq_ff <= 1'b0;
		else
			irq_ff <= done_flag_ff && irq_mask_ff;
	end
	assign o_irq = irq_ff;

	// alignment reads the live bit, so a change shows without a new conversion
	result_aligner i_result_aligner (
		.i_code(result_ff),
		.i_left(select_ff.left_adjust_result),
		.o_low(low_byte),
		.o_high(high_byte)
	);

	// ==================== read channel ====================
	// result bytes take the live alignment bit at read time
	always_comb begin
		nxt_rresp = `AXI_OKAY;
		case (i_araddr)
			`OFS_SELECT: nxt_rdata = {24'h000000, select_ff};
			`OFS_RESULT_LO: nxt_rdata = {24'h000000, low_byte};
			`OFS_RESULT_HI: nxt_rdata = {24'h000000, high_byte};
			`OFS_CONTROL: nxt_rdata = {30'h00000000, state_ff != adc_fmt_pkg::ST_IDLE, 1'b0};
			`OFS_IRQ_STATUS: nxt_rdata = {31'h00000000, done_flag_ff};
			`OFS_IRQ_MASK: nxt_rdata = {31'h00000000, irq_mask_ff};
			`OFS_APPLIED: nxt_rdata = {23'h000000, route_ff};
			default: begin
				nxt_rdata = 32'h00000000;
				nxt_rresp = `AXI_SLVERR;
			end
		endcase
	end

	// data are captured when the address is taken and stand until rready
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= `AXI_OKAY;
		end else if (i_arvalid && arready_ff) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
		end else if (i_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// one read at a time: the slot frees once the answer has been taken
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			arready_ff <= 1'b1;
		end else if (i_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
		end else if (i_rready) begin
			arready_ff <= 1'b1;
		end
	end

	assign o_arready = arready_ff;
	assign o_rvalid = rvalid_ff;
	assign o_rdata = rdata_ff;
	assign o_rresp = rresp_ff;
endmodule : adc_result_format_ref_select

// ==== dv/adc_fmt_asserts.sv ====
`timescale 1ns/1ps
module adc_fmt_asserts (
	input wire logic i_clock, // clock
	input wire logic i_arst_n, // reset
	input wire logic [7:0] i_awaddr, // aw addr
	input wire logic i_awvalid, // aw valid
	input wire logic o_awready, // aw ready
	input wire logic [7:0] i_araddr, // ar addr
	input wire logic i_arvalid, // ar valid
	input wire logic o_arready, // ar ready
	input wire logic [1:0] o_bresp, // b resp
	input wire logic o_bvalid, // b valid
	input wire logic i_bready, // b ready
	input wire logic [31:0] o_rdata, // r data
	input wire logic [1:0] o_rresp, // r resp
	input wire logic o_rvalid, // r valid
	input wire logic i_rready, // r ready
	input wire logic o_conv_start, // start
	input wire logic i_conv_done, // done
	input wire adc_fmt_pkg::route_t o_route // route
);
	// ==========
	// taken addresses and a pending-conversion flag
	logic [7:0] aw_ff;
	logic [7:0] ar_ff;
	logic busy_ff;
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) begin
			aw_ff <= 8'h00;
			ar_ff <= 8'h00;
		end else begin
			if (i_awvalid && o_awready) aw_ff <= i_awaddr;
			if (i_arvalid && o_arready) ar_ff <= i_araddr;
		end
	end
	// done wins over start, so a stray done never leaves the flag stuck
	always_ff @(posedge i_clock or negedge i_arst_n) begin
		if (!i_arst_n) busy_ff <= 1'b0;
		else if (i_conv_done) busy_ff <= 1'b0;
		else if (o_conv_start) busy_ff <= 1'b1;
	end
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_arst_n);
	a_start_pulse: assert property (o_conv_start |=> !o_conv_start)
		else $error("start pulse too long");
	a_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
	a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read not answered");
	a_route_frozen: assert property (busy_ff && !i_conv_done |=> $stable(o_route))
		else $error("route moved mid conversion");
	a_ro_write: assert property (o_bvalid && aw_ff inside {8'h04, 8'h08, 8'h18} |-> o_bresp == 2'h2)
		else $error("read-only write accepted");
	a_bad_read: assert property (o_rvalid && ar_ff > 8'h18 |-> o_rresp == 2'h2 && o_rdata == 32'h0)
		else $error("unmapped read accepted");
	a_sel_width: assert property (o_rvalid && ar_ff == 8'h00 |-> o_rdata[31:8] == 24'h0)
		else $error("select wider than a byte");
	a_ref_onehot: assert property ($onehot0({o_route.ref_external, o_route.ref_supply, o_route.ref_internal}))
		else $error("two references at once");
endmodule : adc_fmt_asserts

// ==== dv/adc_result_format_ref_select_test.sv ====
`timescale 1ns/1ps
module adc_result_format_ref_select_test;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic [7:0] i_awaddr = 8'h00;
	logic [7:0] i_araddr = 8'h00;
	logic [2:0] i_awprot = 3'h0;
	logic [2:0] i_arprot = 3'h0;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'hF;
	logic i_awvalid = 1'b0;
	logic i_wvalid = 1'b0;
	logic i_bready = 1'b0;
	logic i_arvalid = 1'b0;
	logic i_rready = 1'b0;
	logic i_conv_done = 1'b0;
	logic signed [11:0] i_conv_raw = 12'sh000;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_conv_start, o_irq;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	adc_fmt_pkg::route_t o_route;
	logic [33:0] exp_q[$];
	logic [11:0] tbl[8] = '{12'h3FF, 12'h400, 12'hFFF, 12'h000, 12'h1FF, 12'h200, 12'hE00, 12'hDFF};
	logic [11:0] raw;
	logic [7:0] sel;
	int miscompares = 0;
	int num_checks = 0;
	int starts = 0;
	adc_result_format_ref_select i_adc_result_format_ref_select (.i_clock, .i_arst_n, .i_awaddr,
		.i_awprot, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
		.o_bvalid, .i_bready, .i_araddr, .i_arprot, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
		.o_rvalid, .i_rready, .o_conv_start, .i_conv_done, .i_conv_raw, .o_route, .o_irq);
	always #12.5 i_clock = ~i_clock;
	// ==========
	// compare and verdict
	task chk(input logic [33:0] seen, input logic [33:0] want);
		num_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : final_report
	// ==========
	// bus cycles: valid and payload held until each ready is sampled
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
		@(posedge i_clock);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (o_awready) i_awvalid <= 1'b0;
			if (o_wready) i_wvalid <= 1'b0;
		end while (!o_bvalid);
		chk(o_bresp, r);
		i_bready <= 1'b0;
	endtask : wr
	// expected read noted first; the watcher takes it when data shows
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
		exp_q.push_back({r, e});
		@(posedge i_clock);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (o_arready) i_arvalid <= 1'b0;
		end while (!o_rvalid);
		i_rready <= 1'b0;
	endtask : rd
	always @(posedge i_clock) begin
		if (o_rvalid && i_rready) chk({o_rresp, o_rdata}, exp_q.pop_front());
	end
	// every start pulse is counted; a start written while busy must add none
	always @(posedge i_clock) begin
		if (o_conv_start === 1'b1) starts++;
	end
	// core side: done pulse, raw value scrambled outside it
	task done(input logic [11:0] r);
		@(posedge i_clock);
		i_conv_done <= 1'b1;
		i_conv_raw <= r;
		@(posedge i_clock);
		i_conv_done <= 1'b0;
		i_conv_raw <= ~r;
		repeat (3) @(posedge i_clock);
	endtask : done
	task rdres(input logic [9:0] c, input logic l);
		rd(8'h04, l ? {24'h0, c[1:0], 6'h00} : {24'h0, c[7:0]});
		rd(8'h08, l ? {24'h0, c[9:2]} : {22'h0, c[9:8]});
	endtask : rdres
	function automatic logic [9:0] shape(input logic signed [11:0] s, input logic d);
		if (d) return (s > 12'sh1FF) ? 10'h1FF : (s < 12'shE00) ? 10'h200 : s[9:0];
		return (s < 12'sh000) ? 10'h000 : (s > 12'sh3FF) ? 10'h3FF : s[9:0];
	endfunction : shape
	function automatic logic [33:0] rte(input logic [7:0] s);
		return {25'h0, s[7:6] == 2'h0, s[7:6] == 2'h1, s[7:6] == 2'h3, s[4] && s[3:1] != 3'h7, s[4:0]};
	endfunction : rte
	// ==========
	// main sequence
	initial begin
		void'($urandom(32'h08023EF3));
		repeat (12) @(posedge i_clock);
		i_arst_n <= 1'b1;
		rd(8'h00, 32'h0);
		rd(8'h1C, 32'h0, 2'h2);
		$display("reset test done");
		wr(8'h00, 32'hFB);
		wr(8'h0C, 32'h1);
		wr(8'h00, 32'h5B);
		wr(8'h0C, 32'h1);
		rd(8'h0C, 32'h2);
		chk(o_route, rte(8'hFB));
		done(12'hFA3);
		chk(o_route, rte(8'h5B));
		rd(8'h0C, 32'h0);
		rdres(10'h3A3, 1'b0);
		wr(8'h00, 32'hFB);
		rdres(10'h3A3, 1'b1);
		wr(8'h04, 32'hFF, 2'h2);
		$display("example test done");
		for (int i = 0; i < 24; i++) begin
			sel = {i[1:0], 6'($urandom)};
			if (i == 3) sel[4:0] = 5'h1A;
			if (i == 5) sel[4:0] = 5'h1F;
			raw = (i < 8) ? tbl[i] : 12'($urandom);
			wr(8'h00, {24'h0, sel});
			wr(8'h0C, 32'h1);
			done(raw);
			chk(o_route, rte(sel));
			rd(8'h00, {24'h0, sel});
			rd(8'h18, 32'(rte(sel)));
			rdres(shape(raw, sel[4] && sel[3:1] != 3'h7), sel[5]);
		end
		$display("sweep test done");
		wr(8'h10, 32'h1);
		wr(8'h14, 32'h1);
		rd(8'h14, 32'h1);
		wr(8'h0C, 32'h1);
		done(12'h000);
		chk(o_irq, 1'b1);
		rd(8'h10, 32'h1);
		wr(8'h10, 32'h1);
		repeat (2) @(posedge i_clock);
		chk(o_irq, 1'b0);
		wr(8'h14, 32'h0);
		wr(8'h0C, 32'h1);
		done(12'h000);
		chk(o_irq, 1'b0);
		rd(8'h10, 32'h1);
		chk(34'(starts), 34'd27);
		$display("interrupt test done");
		final_report();
	end
	// about 700 cycles are needed; a hang stops well past that
	initial begin
		#500000;
		miscompares++;
		final_report();
	end
endmodule : adc_result_format_ref_select_test
bind adc_result_format_ref_select adc_fmt_asserts i_adc_fmt_asserts (.i_clock, .i_arst_n, .i_awaddr,
	.i_awvalid, .o_awready, .i_araddr, .i_arvalid, .o_arready, .o_bresp, .o_bvalid, .i_bready,
	.o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_conv_start, .i_conv_done, .o_route);
